/* File: pkg/pds_pkg.sv */
// package for the port device status register block
// Functional notes
// (R01) bits 15:6 and 4 read zero; writes to them are ignored
// (R02) software writes zeros into reserved bits 15:6
// (R03) bit 5 reads one while any transaction or completion is outstanding
// (R04) bit 3 sets on a received unsupported request, enables regardless
// (R05) unsupported request also sets non-fatal or fatal flag by severity
// (R06) bit 2 sets on detected fatal error, ignoring enables and mask
// (R07) bit 1 sets on detected non-fatal error, ignoring enables and mask
// (R08) bit 0 sets on detected correctable error, ignoring enables, mask
// (R09) only self-detected errors set flags, never received error messages
// (R10) writing one clears bits 3:0, zero leaves them; reset clears all
package pds_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  PDS_OFFSET      = 8'haa;
    localparam logic [15:0] PDS_RESET       = 16'h0000;
    localparam int          PDS_BIT_CORR    = 0;
    localparam int          PDS_BIT_NONFATAL = 1;
    localparam int          PDS_BIT_FATAL   = 2;
    localparam int          PDS_BIT_UNSUPP  = 3;
    localparam int          PDS_BIT_PENDING = 5;
    localparam logic [3:0]  PDS_FLAGS_RESET = 4'h0;
    localparam int          PDS_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // one-cycle event pulses from the port's own detection logic
    typedef struct packed {
        logic unsupported;
        logic unsupported_fatal;
        logic fatal;
        logic nonfatal;
        logic correctable;
    } pds_events_t;

    // configuration access to the register
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } pds_cfg_req_t;

endpackage : pds_pkg

/* File: rtl/pds_sync.sv */
// two-flop synchroniser for the pending level
`timescale 1ns/10ps
module pds_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // level
    input  wire logic din,
    output logic      dout
);

    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = stage1;
        next_dout   = dout;
        if (!reset_n) begin
            next_stage1 = 1'b0;
            next_dout   = 1'b0;
        end else if (clk_en) begin
            next_stage1 = din;
            next_dout   = stage1;
        end
    end

    always_ff @(posedge clk_sys) begin
        stage1 <= next_stage1;
        dout   <= next_dout;
    end

endmodule : pds_sync

/* File: rtl/pds_status.sv */
// port device status register: sticky error flags and pending level
`timescale 1ns/10ps
module pds_status (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    // detection events from the port logic, same clock
    input  wire pds_pkg::pds_events_t  events,
    // outstanding-transaction level from the link side
    input  wire logic                  pending_async,
    // configuration access
    input  wire pds_pkg::pds_cfg_req_t cfg_req,
    output logic [15:0]                cfg_rdata,
    output logic                       cfg_rvalid,
    // live view of the register
    output logic [15:0]                port_device_status
);

    // ------------------------------------------------------------
    // pending level
    // ------------------------------------------------------------
    logic transactions_outstanding;

    pds_sync u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .din     (pending_async),
        .dout    (transactions_outstanding)
    );

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    // received error messages never reach this port: only the port's own
    // detectors drive events [R09]
    logic       unsupported_request_seen;
    logic       fatal_error_seen;
    logic       nonfatal_error_seen;
    logic       correctable_error_seen;
    logic [3:0] flags;
    logic [3:0] set_vec;
    logic [3:0] clr_vec;
    logic [3:0] next_flags;
    logic [15:0] status_word;
    logic [15:0] next_cfg_rdata;
    logic        next_cfg_rvalid;
    logic        hit;

    assign unsupported_request_seen = flags[pds_pkg::PDS_BIT_UNSUPP];
    assign fatal_error_seen         = flags[pds_pkg::PDS_BIT_FATAL];
    assign nonfatal_error_seen      = flags[pds_pkg::PDS_BIT_NONFATAL];
    assign correctable_error_seen   = flags[pds_pkg::PDS_BIT_CORR];

    assign hit = (cfg_req.addr == pds_pkg::PDS_OFFSET);

    always_comb begin
        set_vec = '0;
        clr_vec = '0;
        // logged whatever the reporting enables or masks say
        set_vec[pds_pkg::PDS_BIT_UNSUPP] = events.unsupported;     // [R04]
        set_vec[pds_pkg::PDS_BIT_FATAL] = events.fatal            // [R06]
            | (events.unsupported & events.unsupported_fatal);     // [R05]
        set_vec[pds_pkg::PDS_BIT_NONFATAL] = events.nonfatal      // [R07]
            | (events.unsupported & ~events.unsupported_fatal);    // [R05]
        set_vec[pds_pkg::PDS_BIT_CORR] = events.correctable;       // [R08]
        // write-one-to-clear, low byte lane only; upper bits ignored [R01]
        if (cfg_req.wr && hit && cfg_req.be[0]) begin
            clr_vec = cfg_req.wdata[3:0];                          // [R10]
        end
        // a new event in the clearing cycle wins over the clear
        next_flags = (flags & ~clr_vec) | set_vec;                 // [R10]
        if (!reset_n) begin
            next_flags = pds_pkg::PDS_FLAGS_RESET;                 // [R10]
        end else if (!clk_en) begin
            next_flags = flags;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        status_word = pds_pkg::PDS_RESET;                          // [R01]
        status_word[pds_pkg::PDS_BIT_PENDING] =
            transactions_outstanding;                              // [R03]
        status_word[pds_pkg::PDS_BIT_UNSUPP]   = next_flags[3];
        status_word[pds_pkg::PDS_BIT_FATAL]    = next_flags[2];
        status_word[pds_pkg::PDS_BIT_NONFATAL] = next_flags[1];
        status_word[pds_pkg::PDS_BIT_CORR]     = next_flags[0];
        next_cfg_rdata  = cfg_rdata;
        next_cfg_rvalid = 1'b0;
        if (!reset_n) begin
            next_cfg_rdata = pds_pkg::PDS_RESET;
        end else if (clk_en) begin
            if (cfg_req.rd && hit) begin
                // flags as held before this edge: a same-cycle clear
                // shows on the next read
                next_cfg_rdata      = status_word;                 // [R01]
                next_cfg_rdata[3:0] = flags;
                next_cfg_rvalid = 1'b1;
            end else if (cfg_req.rd) begin
                // unmapped offsets answer zero
                next_cfg_rdata  = pds_pkg::PDS_RESET;
                next_cfg_rvalid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        flags              <= next_flags;
        cfg_rdata          <= next_cfg_rdata;
        cfg_rvalid         <= next_cfg_rvalid;
        port_device_status <= status_word;
    end

endmodule : pds_status

/* File: sim/pds_link_model.sv */
// link-side model: one non-posted request waiting for its completion
`timescale 1ns/10ps
module pds_link_model (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       np_issue,
    input  wire logic [7:0] np_delay,
    output logic            pending_async
);
    logic [7:0] owed = 8'h00;
    always @(posedge clk_sys) begin
        if (!reset_n) owed <= 8'h00;
        else if (np_issue) owed <= np_delay;
        else if (owed != 8'h00) owed <= owed - 8'h01;
    end
    // skewed 1.3 ns after the clock edge so the level changes between edges, at a fixed phase
    assign #1.3 pending_async = (owed != 8'h00);
endmodule : pds_link_model

/* File: sim/pds_status_props.sv */
// checker for the port device status register
`timescale 1ns/10ps
module pds_status_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire pds_pkg::pds_events_t events,
    input wire logic pending_async,
    input wire pds_pkg::pds_cfg_req_t cfg_req,
    input wire logic [15:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic [15:0] port_device_status
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n || !clk_en);
    wire [15:0] s = port_device_status;
    sequence clr_hit;
        cfg_req.wr && cfg_req.addr == 8'haa && cfg_req.be[0];
    endsequence
    rsvd_zero_a: assert property (!s[4] && s[15:6] == 10'h0)
        else $error("reserved bit set");
    pend_track_a: assert property (
        $stable(pending_async) [*4] |-> s[5] == pending_async)
        else $error("pending bit wrong");
    unsupp_set_a: assert property (events.unsupported |=> s[3])
        else $error("unsupported flag missed");
    unsupp_sev_a: assert property (events.unsupported |=>
        $past(events.unsupported_fatal) ? s[2] : s[1])
        else $error("severity flag missed");
    fatal_set_a: assert property (events.fatal |=> s[2])
        else $error("fatal flag missed");
    nonfatal_set_a: assert property (events.nonfatal |=> s[1])
        else $error("nonfatal flag missed");
    corr_set_a: assert property (events.correctable |=> s[0])
        else $error("correctable flag missed");
    rd_answer_a: assert property (cfg_req.rd |=> cfg_rvalid)
        else $error("read not answered");
    rdata_rsvd_a: assert property (
        cfg_rvalid |-> !cfg_rdata[4] && cfg_rdata[15:6] == 10'h0)
        else $error("reserved read bit set");
    flag_clear_a: assert property (
        clr_hit ##0 (cfg_req.wdata[3] && !events.unsupported) |=> !s[3])
        else $error("flag not cleared");
endmodule : pds_status_props
bind pds_status pds_status_props pds_status_props_inst (.clk_sys, .reset_n,
    .clk_en, .events, .pending_async, .cfg_req, .cfg_rdata, .cfg_rvalid,
    .port_device_status);

/* File: sim/pds_status_tb_top.sv */
// self-checking bench for the port device status register
`timescale 1ns/10ps
module pds_status_tb_top;
    logic clk_sys = 0, reset_n = 0, np_issue = 0, pending_async, cfg_rvalid;
    logic [7:0] np_delay = 8'h28;
    logic [15:0] cfg_rdata, port_device_status, notes[$];
    logic [3:0] flags = 4'h0;
    pds_pkg::pds_events_t events = '0;
    pds_pkg::pds_cfg_req_t cfg_req = '0;
    int num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'hb45b;
    pds_status pds_status_inst (.clk_sys, .reset_n, .clk_en(1'b1), .events,
        .pending_async, .cfg_req, .cfg_rdata, .cfg_rvalid, .port_device_status);
    pds_link_model pds_link_model_inst (.clk_sys, .reset_n, .np_issue,
        .np_delay, .pending_async);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic check(logic [15:0] seen, logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cfg_rvalid && notes.size() == 0) num_errors++;
        else if (cfg_rvalid) check(cfg_rdata, notes.pop_front());
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic rd(logic [7:0] a, logic [15:0] want);
        cfg_req <= '{1'b1, 1'b0, a, 2'h3, 16'h0000};
        notes.push_back(want);
        @(posedge clk_sys) cfg_req <= '0;
    endtask : rd
    task automatic wr(logic [15:0] d);
        cfg_req <= '{1'b0, 1'b1, 8'haa, 2'h3, d & 16'h003f};
        flags = flags & ~d[3:0];
        @(posedge clk_sys) cfg_req <= '0;
    endtask : wr
    task automatic ev(pds_pkg::pds_events_t v);
        events <= v;
        flags |= {v.unsupported, v.fatal | v.unsupported & v.unsupported_fatal,
            v.nonfatal | v.unsupported & ~v.unsupported_fatal,
            v.correctable};
        @(posedge clk_sys) events <= '0;
    endtask : ev
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        rd(8'haa, 16'h0000);
        // every event mix first, then random mixes; each mix is followed by a random clear
        for (int i = 0; i < 80; i++) begin
            ev(i < 32 ? 5'(i) : 5'($random(seed)));
            rd(8'haa, {12'h000, flags});
            wr(16'($random(seed)));
            rd(8'haa, {12'h000, flags});
        end
        rd(8'ha8, 16'h0000);
        np_issue <= 1;
        @(posedge clk_sys) np_issue <= 0;
        repeat (6) @(posedge clk_sys);
        rd(8'haa, {10'h000, 1'b1, 1'b0, flags});
        check(port_device_status, {10'h000, 1'b1, 1'b0, flags});
        repeat (45) @(posedge clk_sys);
        rd(8'haa, {12'h000, flags});
        repeat (4) @(posedge clk_sys);
        check(port_device_status, {12'h000, flags});
        if (notes.size() != 0) num_errors++;
        give_verdict();
    end
endmodule : pds_status_tb_top
